//--- shared/tx_char_pkg.sv
// Constants, tables and types for the transmit character path.
package tx_char_pkg;

  // Three-level strap encoding on the two-bit select ports.
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  // Layout of the synchronised pin vector.
  localparam int PIN_W = 22;
  localparam int POS_REF_CLK = 0;
  localparam int POS_HOST_CLK = 1;
  localparam int POS_DATA = 2;
  localparam int POS_CTL = 10;
  localparam int POS_PARITY = 12;
  localparam int POS_SPECIAL = 13;
  localparam int POS_PAR_SEL = 14;
  localparam int POS_MODE = 16;
  localparam int POS_CLK_SEL = 20;

  // Values after reset.
  localparam logic [PIN_W-1:0] PIN_RESET = 22'h000000;
  localparam logic [9:0] CHAR_RESET = 10'h000;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;
  localparam logic [3:0] REMAIN_RESET = 4'h0;

  // Word sync sequence: characters left after the starting one.
  localparam logic [3:0] SYNC_REMAIN = 4'hF;
  localparam logic [3:0] SYNC_LAST = 4'h1;

  localparam logic [7:0] FILL_CODE = 8'hBC;
  localparam logic [4:0] K28_X = 5'h1C;
  localparam logic [5:0] K28_SIX = 6'h0F;
  localparam logic [3:0] ALT7_FOUR = 4'h7;
  localparam logic [9:0] VIOLATION_POS = 10'h278;
  localparam logic [9:0] VIOLATION_NEG = 10'h187;

  // 5b/6b codes for negative running disparity, bit 5 is a, bit 0 is i.
  localparam logic [5:0] CODE6 [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};

  // 3b/4b codes for negative running disparity, bit 3 is f, bit 0 is j.
  localparam logic [3:0] CODE4 [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'h1,
    SYNC_RUN = 2'h2
  } sync_state_type;

endpackage : tx_char_pkg

//--- rtl/tx_parity_check_and_char_encoder.sv
// Transmit parity check, 8B/10B character encoder and serial shifter.
//
// Overview of operation
// - Odd parity checking with an extra parity input in every mode.
// - Selector mid with encoder on checks only data bits plus parity bit.
// - Data, control and parity bits checked: selector high, or mid in bypass.
// - Parity selector low disables all parity checking.
// - Parity is good only when the XOR of checked bits is one.
// - Encoded parity error sends a violation character of correct disparity.
// - Bypass parity error sends the fixed positive violation pattern.
// - Transmit parity errors are reported on the error flag output.
// - While a buffer error is present and BIST is off the violation character is sent.
// - Encoder on converts data or special codes per control and select.
// - Each 10-bit character goes to the shifter and leaves LSB first.
// - The upper three-level mode input picks bypass, atomic or interruptible.
// - Modes 3 and 6 map select and control to data, fill, special, sync.
// - Bypass forwards data and control bits unchanged as one character.
// - Bypass maps data 0-4 to a-e, 5 to i, 6 f, 7 g, h, j.
// - Bypass ignores special select and reads data alike in all clockings.
// - Clock selector mid or high captures on the host transmit clock.
// - Active BIST sends a repeating 511-character sequence instead.
// - An atomic word sync runs all sixteen characters, ignoring input.
// - A buffer error holds the error flag until the buffer is reset or recentred by an atomic sync start.
module tx_parity_check_and_char_encoder (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic reference_clock_in,
  input wire logic host_transmit_input_clock_in,
  input wire logic [7:0] transmit_data_in,
  input wire logic [1:0] transmit_control_in,
  input wire logic odd_parity_bit_in,
  input wire logic special_code_select_in,
  input wire logic [1:0] parity_check_select_in,
  input wire logic [3:0] transmit_mode_select_in,
  input wire logic [1:0] transmit_clock_source_select_in,
  input wire logic buffer_error_in,
  input wire logic buffer_reset_in,
  input wire logic bist_active_in,
  output logic [9:0] char_out,
  output logic char_strobe_out,
  output logic serial_data_out,
  output logic transmit_error_flag_out
);

  // Encodes one byte, data or special, at running disparity rd
  // (0 negative). Returns {running disparity after, 10-bit character}.
  function automatic logic [10:0] encode(input logic [7:0] b,
                                         input logic k,
                                         input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] six;
    logic [3:0] four;
    logic rd6;
    logic alt;
    logic bal4;
    x = b[4:0];
    y = b[7:5];
    six = (k && x == tx_char_pkg::K28_X) ? tx_char_pkg::K28_SIX
                                         : tx_char_pkg::CODE6[x];
    rd6 = ($countones(six) != 3) ? ~rd : rd;
    if (rd && ($countones(six) != 3 || (x == 5'h07 && !k))) begin
      six = ~six;
    end
    alt = (y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 ||
          x == 5'h14)) || (rd6 && (x == 5'h0B || x == 5'h0D ||
          x == 5'h0E)));
    four = alt ? tx_char_pkg::ALT7_FOUR : tx_char_pkg::CODE4[y];
    bal4 = ($countones(four) == 2);
    if (k && x == tx_char_pkg::K28_X && bal4 && y != 3'h3) begin
      if (!rd6) begin
        four = ~four;
      end
    end else if (rd6 && (!bal4 || y == 3'h3)) begin
      four = ~four;
    end
    encode = {(bal4 ? rd6 : ~rd6), four[0], four[1], four[2], four[3],
              six[0], six[1], six[2], six[3], six[4], six[5]};
  endfunction : encode

  // True for the special codes that have a valid 10-bit form.
  function automatic logic special_valid(input logic [7:0] b);
    special_valid = (b[4:0] == tx_char_pkg::K28_X) ||
                    (b[7:5] == 3'h7 && (b[4:0] == 5'h17 ||
                     b[4:0] == 5'h1B || b[4:0] == 5'h1D ||
                     b[4:0] == 5'h1E));
  endfunction : special_valid

  // Pin inputs pass three flip-flops; a bit is taken once stages two
  // and three agree.
  logic [tx_char_pkg::PIN_W-1:0] pin_raw;
  logic [tx_char_pkg::PIN_W-1:0] pin_s1;
  logic [tx_char_pkg::PIN_W-1:0] pin_s2;
  logic [tx_char_pkg::PIN_W-1:0] pin_s3;
  logic [tx_char_pkg::PIN_W-1:0] pin;
  logic [tx_char_pkg::PIN_W-1:0] next_pin;

  assign pin_raw = {transmit_clock_source_select_in,
                    transmit_mode_select_in, parity_check_select_in,
                    special_code_select_in, odd_parity_bit_in,
                    transmit_control_in, transmit_data_in,
                    host_transmit_input_clock_in, reference_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < tx_char_pkg::PIN_W; gi++) begin : g_filter
      assign next_pin[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi]
                                                        : pin[gi];
    end
  endgenerate

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_s1 <= tx_char_pkg::PIN_RESET;
      pin_s2 <= tx_char_pkg::PIN_RESET;
      pin_s3 <= tx_char_pkg::PIN_RESET;
      pin <= tx_char_pkg::PIN_RESET;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin <= next_pin;
    end
  end

  // Strap decode.
  wire [1:0] clk_sel = pin[tx_char_pkg::POS_CLK_SEL +: 2];
  wire [1:0] mode_hi = pin[tx_char_pkg::POS_MODE + 2 +: 2];
  wire [1:0] mode_lo = pin[tx_char_pkg::POS_MODE +: 2];
  wire [1:0] par_sel = pin[tx_char_pkg::POS_PAR_SEL +: 2];
  wire encoder_on = (mode_hi != tx_char_pkg::LEVEL_LOW);
  wire atomic_mode = (mode_hi == tx_char_pkg::LEVEL_MID);
  wire use_host_clk = (clk_sel != tx_char_pkg::LEVEL_LOW);

  // Character strobe from the rising edge of the selected input clock.
  logic clk_prev;
  wire sel_clk = use_host_clk ? pin[tx_char_pkg::POS_HOST_CLK]
                              : pin[tx_char_pkg::POS_REF_CLK];
  wire capture = sel_clk & ~clk_prev;

  // Input register.
  logic [7:0] cap_data;
  logic [1:0] cap_ctl;
  logic cap_parity;
  logic cap_special;
  logic cap_valid;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_prev <= 1'b0;
      cap_data <= 8'h00;
      cap_ctl <= 2'h0;
      cap_parity <= 1'b0;
      cap_special <= 1'b0;
      cap_valid <= 1'b0;
    end else begin
      clk_prev <= sel_clk;
      cap_valid <= capture;
      if (capture) begin
        cap_data <= pin[tx_char_pkg::POS_DATA +: 8];
        cap_ctl <= pin[tx_char_pkg::POS_CTL +: 2];
        cap_parity <= pin[tx_char_pkg::POS_PARITY];
        cap_special <= pin[tx_char_pkg::POS_SPECIAL];
      end
    end
  end

  // Parity check on the captured character.
  wire check_ctl = (par_sel == tx_char_pkg::LEVEL_HIGH) || !encoder_on;
  wire parity_xor = ^cap_data ^ cap_parity ^
                    (check_ctl ? ^cap_ctl : 1'b0);
  wire parity_on = (par_sel != tx_char_pkg::LEVEL_LOW);
  wire parity_bad = parity_on && !parity_xor;

  // Character class from control and select, per mode column.
  logic want_data;
  logic want_fill;
  logic want_special;
  logic want_sync;

  always_comb begin
    want_data = 1'b0;
    want_fill = 1'b0;
    want_special = 1'b0;
    want_sync = 1'b0;
    case (mode_lo)
      tx_char_pkg::LEVEL_LOW: begin
        want_data = !cap_ctl[0];
        want_fill = (cap_ctl == 2'h1) && !cap_special;
        want_special = (cap_ctl == 2'h1) && cap_special;
        want_sync = (cap_ctl == 2'h3);
      end
      tx_char_pkg::LEVEL_MID: begin
        want_data = !cap_ctl[0];
        want_fill = (cap_ctl == 2'h1) && !cap_special;
        want_special = (cap_ctl == 2'h3) && !cap_special;
        want_sync = cap_ctl[0] && cap_special;
      end
      default: begin
        want_data = (cap_ctl == 2'h0);
        want_fill = (cap_ctl == 2'h1);
        want_special = (cap_ctl == 2'h2);
        want_sync = (cap_ctl == 2'h3);
      end
    endcase
  end

  // Running state.
  logic rd;
  tx_char_pkg::sync_state_type sync_state;
  logic [3:0] sync_remain;
  logic buffer_fault;
  logic [8:0] lfsr;
  logic [9:0] shift;

  // Encoded candidates.
  wire [10:0] enc_fill = encode(tx_char_pkg::FILL_CODE, 1'b1, rd);
  wire [10:0] enc_data = encode(cap_data, 1'b0, rd);
  wire [10:0] enc_special = encode(cap_data, 1'b1, rd);
  wire [10:0] enc_bist = encode(lfsr[7:0], lfsr[8], rd);
  wire bist_violation = lfsr[8] && !special_valid(lfsr[7:0]);
  wire special_bad = !special_valid(cap_data);
  wire [9:0] violation = rd ? tx_char_pkg::VIOLATION_POS
                            : tx_char_pkg::VIOLATION_NEG;
  wire in_sync = (sync_state == tx_char_pkg::SYNC_RUN);
  wire sync_continue = in_sync && !atomic_mode && (cap_ctl == 2'h0);

  // Next character selection, in priority order.
  logic [9:0] next_char;
  logic next_rd;
  logic next_par_err;
  logic sync_start;
  logic sync_step;

  always_comb begin
    next_char = tx_char_pkg::CHAR_RESET;
    next_rd = rd;
    next_par_err = 1'b0;
    sync_start = 1'b0;
    sync_step = 1'b0;
    if (bist_active_in) begin
      if (bist_violation) begin
        next_char = violation;
      end else begin
        {next_rd, next_char} = enc_bist;
      end
    end else if (buffer_fault) begin
      next_char = violation;
    end else if (!encoder_on) begin
      if (parity_bad) begin
        next_char = tx_char_pkg::VIOLATION_POS;
        next_par_err = 1'b1;
      end else begin
        next_char = {cap_ctl, cap_data};
      end
    end else if (in_sync && atomic_mode) begin
      {next_rd, next_char} = enc_fill;
      sync_step = 1'b1;
    end else if (parity_bad) begin
      next_char = violation;
      next_par_err = 1'b1;
    end else if (sync_continue) begin
      {next_rd, next_char} = enc_fill;
      sync_step = 1'b1;
    end else if (want_sync || want_fill) begin
      {next_rd, next_char} = enc_fill;
      sync_start = want_sync;
    end else if (want_special) begin
      if (special_bad) begin
        next_char = violation;
      end else begin
        {next_rd, next_char} = enc_special;
      end
    end else if (want_data) begin
      {next_rd, next_char} = enc_data;
    end else begin
      next_char = violation;
    end
  end

  // Word sync sequence state machine.
  tx_char_pkg::sync_state_type next_sync_state;
  logic [3:0] next_sync_remain;

  always_comb begin
    next_sync_state = sync_state;
    next_sync_remain = sync_remain;
    case (sync_state)
      tx_char_pkg::SYNC_IDLE: begin
        if (cap_valid && sync_start) begin
          next_sync_state = tx_char_pkg::SYNC_RUN;
          next_sync_remain = tx_char_pkg::SYNC_REMAIN;
        end
      end
      tx_char_pkg::SYNC_RUN: begin
        if (cap_valid) begin
          if (sync_start) begin
            next_sync_remain = tx_char_pkg::SYNC_REMAIN;
          end else if (sync_step && sync_remain > tx_char_pkg::SYNC_LAST) begin
            next_sync_remain = sync_remain - 4'h1;
          end else begin
            next_sync_state = tx_char_pkg::SYNC_IDLE;
            next_sync_remain = tx_char_pkg::REMAIN_RESET;
          end
        end
      end
      default: begin
        next_sync_state = tx_char_pkg::SYNC_IDLE;
        next_sync_remain = tx_char_pkg::REMAIN_RESET;
      end
    endcase
  end

  // Buffer fault is sticky; a new error wins over a reset in the same
  // cycle. An atomic sync start recentres the buffer and clears it.
  wire recentre = cap_valid && atomic_mode && want_sync && !in_sync &&
                  !parity_bad && !bist_active_in;
  wire next_buffer_fault = buffer_error_in ||
                           (buffer_fault && !buffer_reset_in &&
                            !recentre);
  wire [8:0] next_lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd <= 1'b0;
      sync_state <= tx_char_pkg::SYNC_IDLE;
      sync_remain <= tx_char_pkg::REMAIN_RESET;
      buffer_fault <= 1'b0;
      lfsr <= tx_char_pkg::LFSR_SEED;
    end else begin
      buffer_fault <= next_buffer_fault;
      sync_state <= next_sync_state;
      sync_remain <= next_sync_remain;
      if (cap_valid) begin
        rd <= next_rd;
        if (bist_active_in) begin
          lfsr <= next_lfsr;
        end
      end
    end
  end

  // Character output and LSB-first shifter.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      char_out <= tx_char_pkg::CHAR_RESET;
      char_strobe_out <= 1'b0;
      shift <= tx_char_pkg::CHAR_RESET;
      serial_data_out <= 1'b0;
      transmit_error_flag_out <= 1'b0;
    end else begin
      char_strobe_out <= cap_valid;
      transmit_error_flag_out <= buffer_fault ||
          (transmit_error_flag_out && !cap_valid) ||
          (cap_valid && next_par_err);
      if (cap_valid) begin
        char_out <= next_char;
        shift <= {1'b0, next_char[9:1]};
        serial_data_out <= next_char[0];
      end else begin
        shift <= {1'b0, shift[9:1]};
        serial_data_out <= shift[0];
      end
    end
  end

endmodule : tx_parity_check_and_char_encoder

//--- tb/tx_char_checker.sv
// Port checks for the transmit character path.
module tx_char_checker (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [1:0] parity_check_select_in,
  input wire logic buffer_error_in,
  input wire logic buffer_reset_in,
  input wire logic bist_active_in,
  input wire logic [9:0] char_out,
  input wire logic char_strobe_out,
  input wire logic serial_data_out,
  input wire logic transmit_error_flag_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fault_seen;
  logic [3:0] fault_age;
  wire fault_clear = buffer_reset_in && !buffer_error_in;
  wire is_viol = (char_out == 10'h278) || (char_out == 10'h187);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_seen <= 1'b0;
    end else if (buffer_error_in) begin
      fault_seen <= 1'b1;
    end else if (fault_clear) begin
      fault_seen <= 1'b0;
    end
  end
  // Counts how long a buffer fault has stood, saturating at 15.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_age <= 4'h0;
    end else if (!fault_seen || fault_clear) begin
      fault_age <= 4'h0;
    end else if (fault_age != 4'hF) begin
      fault_age <= fault_age + 4'h1;
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_strobe_gap;
    char_strobe_out |=> !char_strobe_out [*6];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("strobe gap");
  property p_char_hold;
    !char_strobe_out |-> $stable(char_out);
  endproperty
  a_char_hold: assert property (p_char_hold) else $error("char moved");
  property p_serial;
    char_strobe_out |-> serial_data_out == char_out[0]
      ##1 serial_data_out == char_out[1] ##1 serial_data_out == char_out[2]
      ##1 serial_data_out == char_out[3] ##1 serial_data_out == char_out[4]
      ##1 serial_data_out == char_out[5] ##1 serial_data_out == char_out[6];
  endproperty
  a_serial: assert property (p_serial) else $error("serial order");
  property p_flag_viol;
    char_strobe_out && transmit_error_flag_out && !bist_active_in |-> is_viol;
  endproperty
  a_flag_viol: assert property (p_flag_viol)
    else $error("no violation");
  property p_buffer_raise;
    $rose(buffer_error_in) |-> ##[1:10] transmit_error_flag_out;
  endproperty
  a_buffer_raise: assert property (p_buffer_raise)
    else $error("no flag");
  property p_buffer_hold;
    fault_age == 4'hF |-> transmit_error_flag_out;
  endproperty
  a_buffer_hold: assert property (p_buffer_hold)
    else $error("flag lost");
  property p_flag_rise;
    $rose(transmit_error_flag_out) |-> char_strobe_out || fault_seen;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag early");
  property p_no_check;
    char_strobe_out && parity_check_select_in == 2'h0 && !fault_seen
      && !$past(fault_seen) && !bist_active_in |-> !transmit_error_flag_out;
  endproperty
  a_no_check: assert property (p_no_check)
    else $error("flag unchecked");
endmodule : tx_char_checker
bind tx_parity_check_and_char_encoder tx_char_checker u_checker (
  .clock_in(clock_in), .arst_n_in(arst_n_in),
  .parity_check_select_in(parity_check_select_in),
  .buffer_error_in(buffer_error_in), .buffer_reset_in(buffer_reset_in),
  .bist_active_in(bist_active_in), .char_out(char_out),
  .char_strobe_out(char_strobe_out), .serial_data_out(serial_data_out),
  .transmit_error_flag_out(transmit_error_flag_out));

//--- tb/host_tx_model.sv
// Host side model: makes the character clocks and drives each character.
module host_tx_model (
  input wire logic use_host_clock_in,
  output logic reference_clock_out,
  output logic host_clock_out,
  output logic [7:0] data_out,
  output logic [1:0] control_out,
  output logic parity_out,
  output logic special_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // The reference clock stands still while the host clock is selected.
  initial begin
    reference_clock_out = 1'b0;
    forever begin
      #80;
      if (!use_host_clock_in) begin
        reference_clock_out = ~reference_clock_out;
      end
    end
  end
  initial begin
    host_clock_out = 1'b0;
    #40;
    forever #80 host_clock_out = ~host_clock_out;
  end
  initial begin
    data_out = 8'hB5;
    control_out = 2'b00;
    special_out = 1'b0;
    parity_out = ~(^8'hB5);
  end
  // Changes the character on a falling edge so it is steady when captured.
  task automatic put(input logic [7:0] d, input logic [1:0] c,
                     input logic s, input logic full, input logic bad);
    if (use_host_clock_in) begin
      @(negedge host_clock_out);
    end else begin
      @(negedge reference_clock_out);
    end
    data_out = d;
    control_out = c;
    special_out = s;
    parity_out = ~(^d ^ (full & ^c)) ^ bad;
  endtask : put
endmodule : host_tx_model

//--- tb/tx_parity_check_and_char_encoder_test.sv
// Self-checking bench for the transmit character path.
module tx_parity_check_and_char_encoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in, arst_n_in, buf_err, buf_rst, bist, got_err;
  logic [1:0] par_sel, clk_sel;
  logic [3:0] mode;
  logic [9:0] got;
  wire ref_clk, host_clk, par_bit, spec, strobe, serial, err;
  wire [7:0] data;
  wire [1:0] ctl;
  wire [9:0] char_val;
  int n_fail = 0;
  int n_checks = 0;
  host_tx_model u_host (.use_host_clock_in(clk_sel != 2'h0),
    .reference_clock_out(ref_clk), .host_clock_out(host_clk),
    .data_out(data), .control_out(ctl), .parity_out(par_bit),
    .special_out(spec));
  tx_parity_check_and_char_encoder u_dut (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .reference_clock_in(ref_clk),
    .host_transmit_input_clock_in(host_clk), .transmit_data_in(data),
    .transmit_control_in(ctl), .odd_parity_bit_in(par_bit),
    .special_code_select_in(spec), .parity_check_select_in(par_sel),
    .transmit_mode_select_in(mode), .transmit_clock_source_select_in(clk_sel),
    .buffer_error_in(buf_err), .buffer_reset_in(buf_rst),
    .bist_active_in(bist), .char_out(char_val), .char_strobe_out(strobe),
    .serial_data_out(serial), .transmit_error_flag_out(err));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  function automatic logic [9:0] is_k(input logic [9:0] x);
    return {9'h000, x === 10'h17C || x === 10'h283};
  endfunction : is_k
  function automatic logic [9:0] is_v(input logic [9:0] x);
    return {9'h000, x === 10'h187 || x === 10'h278};
  endfunction : is_v
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t: saw %h, want %h", $time, seen, want);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // Waits for n strobes and keeps what the last one carried.
  task automatic look(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(negedge clock_in);
      while (strobe !== 1'b1 && k < 40) begin
        @(negedge clock_in);
        k++;
      end
      if (strobe !== 1'b1) begin
        n_fail++;
        $display("BAD %0t: no strobe", $time);
      end
      got = char_val;
      got_err = err;
    end
  endtask : look
  task automatic step(input logic [7:0] d, input logic [1:0] c,
                      input logic s, input logic full, input logic bad);
    u_host.put(d, c, s, full, bad);
    look(2);
  endtask : step
  task automatic setup(input logic [3:0] m, input logic [1:0] p);
    @(negedge clock_in);
    mode = m;
    par_sel = p;
  endtask : setup
  task automatic do_reset(input logic [1:0] cs);
    @(negedge clock_in);
    arst_n_in = 1'b0;
    clk_sel = cs;
    repeat (10) @(negedge clock_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask : do_reset
  task automatic t_enc_parity;
    setup(4'h4, 2'h1);
    step(8'hB5, 2'b00, 1'b0, 1'b0, 1'b0);
    check(got, 10'h155);
    step(8'hB5, 2'b00, 1'b0, 1'b0, 1'b1);
    check(got, 10'h187);
    check({9'h000, got_err}, 10'h001);
    step(8'hBC, 2'b01, 1'b0, 1'b0, 1'b0);
    check({is_k(got)}, 10'h001);
    check({9'h000, got_err}, 10'h000);
    setup(4'h4, 2'h2);
    step(8'hBC, 2'b01, 1'b0, 1'b0, 1'b0);
    check(is_v(got), 10'h001);
    step(8'hB5, 2'b00, 1'b0, 1'b1, 1'b0);
  endtask : t_enc_parity
  task automatic t_bypass;
    logic [9:0] v [4];
    v = '{10'h2A5, 10'h13C, 10'h3FF, 10'h000};
    for (int cs = 0; cs < 3; cs++) begin
      do_reset(cs[1:0]);
      setup(4'h0, 2'h0);
      for (int i = 0; i < 4; i++) begin
        step(v[i][7:0], v[i][9:8], i[0], 1'b1, 1'b0);
        check(got, v[i]);
      end
    end
  endtask : t_bypass
  task automatic t_bypass_parity;
    for (int p = 1; p < 3; p++) begin
      setup(4'h0, p[1:0]);
      step(8'h5A, 2'b10, 1'b0, 1'b1, 1'b0);
      check(got, 10'h25A);
      step(8'h5A, 2'b10, 1'b0, 1'b1, 1'b1);
      check(got, 10'h278);
      check({9'h000, got_err}, 10'h001);
      step(8'h5A, 2'b10, 1'b0, 1'b0, 1'b0);
      check({9'h000, got_err}, 10'h001);
      step(8'h5A, 2'b10, 1'b0, 1'b1, 1'b0);
    end
    setup(4'h0, 2'h0);
    step(8'h5A, 2'b10, 1'b0, 1'b1, 1'b1);
    check({got_err, got}, 11'h25A);
  endtask : t_bypass_parity
  task automatic t_modes;
    logic [3:0] m [7];
    m = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
    for (int i = 0; i < 7; i++) begin
      setup(m[i], 2'h0);
      step(8'hB5, 2'b00, 1'b0, 1'b1, 1'b0);
      check(got, (i == 0) ? 10'h0B5 : 10'h155);
    end
  endtask : t_modes
  task automatic t_fill;
    logic [9:0] a;
    setup(4'h4, 2'h0);
    step(8'hBC, 2'b01, 1'b0, 1'b1, 1'b0);
    a = got;
    look(1);
    check(a ^ got, 10'h3FF);
    check(is_k(a), 10'h001);
    step(8'hBC, 2'b01, 1'b1, 1'b1, 1'b0);
    check(is_k(got), 10'h001);
    setup(4'h6, 2'h0);
    step(8'hBC, 2'b10, 1'b0, 1'b1, 1'b0);
    check(is_k(got), 10'h001);
  endtask : t_fill
  task automatic t_sync;
    int n;
    for (int i = 0; i < 2; i++) begin
      setup((i == 0) ? 4'h4 : 4'h8, 2'h0);
      step(8'hB5, 2'b00, 1'b0, 1'b1, 1'b0);
      u_host.put(8'hB5, 2'b11, 1'b0, 1'b1, 1'b0);
      u_host.put(8'hB5, 2'b10, 1'b0, 1'b1, 1'b0);
      n = 0;
      for (int k = 0; k < 24; k++) begin
        look(1);
        n = n + int'(is_k(got) === 10'h001);
      end
      check(n[9:0], (i == 0) ? 10'h010 : 10'h001);
    end
  endtask : t_sync
  task automatic t_buffer;
    setup(4'h4, 2'h0);
    step(8'hB5, 2'b00, 1'b0, 1'b1, 1'b0);
    @(negedge clock_in);
    buf_err = 1'b1;
    look(2);
    check({got_err, is_v(got)}, 11'h401);
    @(negedge clock_in);
    buf_err = 1'b0;
    look(3);
    check({got_err, is_v(got)}, 11'h401);
    @(negedge clock_in);
    buf_rst = 1'b1;
    @(negedge clock_in);
    buf_rst = 1'b0;
    look(3);
    check({got_err, got}, 11'h155);
  endtask : t_buffer
  task automatic t_bist;
    int n;
    @(negedge clock_in);
    bist = 1'b1;
    n = 0;
    look(2);
    for (int k = 0; k < 8; k++) begin
      look(1);
      n = n + int'(got !== 10'h155);
    end
    check({9'h000, n > 3}, 10'h001);
    @(negedge clock_in);
    bist = 1'b0;
    look(3);
    check(got, 10'h155);
  endtask : t_bist
  initial begin
    #200us;
    n_fail++;
    stop_test;
  end
  initial begin
    {arst_n_in, buf_err, buf_rst, bist, par_sel, clk_sel} = 8'h00;
    mode = 4'h4;
    do_reset(2'h0);
    t_enc_parity;
    t_bypass;
    t_bypass_parity;
    t_modes;
    t_fill;
    t_sync;
    t_buffer;
    t_bist;
    stop_test;
  end
endmodule : tx_parity_check_and_char_encoder_test
